// ==== macp_parser.sv ====
// Command-line parser: queues characters, edits and filters lines, echoes whole
// lines and hands finished lines to the command engine.
// Assumes a byte stream from a UART on core_clk_i and an engine that takes a
// line on a one-cycle strobe while reading it from line_char_o by index.
// Behaviour
// - One command per line; echo the whole line only after its terminator.
// - In program entry, backspace or illegal character clears line, resends line number.
// - Lines end with carriage return; interpretation starts only then.
// - Command letter may touch its first value; later values need separators.
// - First program page spans locations zero through 191.
// - Motion commands take five locations, others about three.
// - Locations 200 to 255 hold parameters only, changed by dedicated commands.
// - Automatic program mode starts at 192, which holds a branch.
// - Naming control prompts for one letter, committed after lowercase y; the code sends no prompt character.
// - Naming works only in single-axis immediate mode.
// - In multi-axis mode each command is prefixed by the axis name.
// - Reset and escape act as broadcasts without a name prefix.
// - In multi-axis mode listen for own name, buffer, interpret, echo.
// - Code 10 hex enters multi-axis mode at once, silently.
// - Characters go through a buffered queue; stepping may stall processing.
// - Store with argument one copies the program into non-volatile memory.
// - Parameter listing reports the stored axis name.
// - The terminator is hex 0D.
// - Escape discards a partially typed line.
`timescale 1ns/1ps
module macp_parser #(
  parameter int LINE_DEPTH = macp_pkg::LINE_DEPTH,
  parameter int QUEUE_DEPTH = macp_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic stepping_busy_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic prog_entry_i,
  input wire logic program_mode_i,
  input wire logic [9:0] prog_line_i,
  output logic line_done_o,
  output logic [5:0] line_len_o,
  input wire logic [4:0] line_idx_i,
  output logic [7:0] line_char_o,
  output logic multi_axis_o,
  output logic [7:0] axis_name_o,
  output logic reset_cmd_o,
  output logic escape_cmd_o,
  output logic store_program_nonvolatile_o,
  output logic [2:0] cmd_size_o,
  output logic addr_fault_o
);
  // ==========================================================
  // Reset release and receive queue
  logic rst_s1_q;
  logic rst_q;
  logic q_valid;
  logic [7:0] q_data;
  logic take;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  macp_rx_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_queue (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_q),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(q_valid),
    .out_ready_i(take),
    .out_data_o(q_data)
  );

  // ==========================================================
  // Line state
  macp_pkg::macp_state_t state_q;
  logic [7:0] line_q [LINE_DEPTH];
  logic [5:0] len_q;
  logic [5:0] echo_q;
  logic echo_tail_q;
  logic [1:0] lnum_q;
  logic [7:0] name_cand_q;
  logic [7:0] ch;
  logic is_letter;
  logic is_legal;
  logic busy;
  logic send_ok;
  logic [7:0] lnum_char;

  assign ch = q_data;
  assign is_letter = (ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h61 && ch <= 8'h7A);
  // Digits, signs, letters and separators may appear in a command line.
  assign is_legal = (ch >= 8'h20 && ch <= 8'h7E);
  assign busy = (state_q == macp_pkg::ST_ECHO) || (state_q == macp_pkg::ST_LNUM);
  assign send_ok = tx_ready_i;
  // Stepping has priority, so characters wait in the queue while it runs.
  assign take = q_valid && !busy && !stepping_busy_i;

  always_comb begin
    lnum_char = 8'h30;
    case (lnum_q)
      2'h2: lnum_char = 8'h30 + 8'(prog_line_i / 100);
      2'h1: lnum_char = 8'h30 + 8'((prog_line_i / 10) % 10);
      default: lnum_char = 8'h30 + 8'(prog_line_i % 10);
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= macp_pkg::ST_IDLE;
      len_q <= 6'h00;
      echo_q <= 6'h00;
      echo_tail_q <= 1'b0;
      lnum_q <= 2'h0;
    end else begin
      case (state_q)
        macp_pkg::ST_IDLE, macp_pkg::ST_LINE: begin
          if (take) begin
            if (ch == macp_pkg::CH_ESC || ch == macp_pkg::CH_RESET) begin
              state_q <= macp_pkg::ST_IDLE;
              len_q <= 6'h00;
            end else if (ch == macp_pkg::CH_MULTI) begin
              state_q <= state_q;
            end else if (ch == macp_pkg::CH_NAME) begin
              if (!multi_axis_o && !program_mode_i && !prog_entry_i &&
                  state_q == macp_pkg::ST_IDLE) begin
                state_q <= macp_pkg::ST_NAME_CHAR;
              end
            end else if (multi_axis_o && state_q == macp_pkg::ST_IDLE) begin
              // The first character addresses the line.
              if (ch == axis_name_o) begin
                state_q <= macp_pkg::ST_LINE;
              end else if (ch != macp_pkg::CH_CR) begin
                state_q <= macp_pkg::ST_SKIP;
              end
            end else if (ch == macp_pkg::CH_CR) begin
              state_q <= macp_pkg::ST_ECHO;
              echo_q <= 6'h00;
              echo_tail_q <= 1'b0;
            end else if (prog_entry_i && (ch == macp_pkg::CH_BS || !is_legal)) begin
              len_q <= 6'h00;
              lnum_q <= 2'h2;
              state_q <= macp_pkg::ST_LNUM;
            end else if (ch == macp_pkg::CH_BS) begin
              len_q <= 6'h00;
              state_q <= multi_axis_o ? macp_pkg::ST_LINE : macp_pkg::ST_IDLE;
            end else if (is_legal && len_q < 6'(LINE_DEPTH)) begin
              len_q <= len_q + 6'h01;
              state_q <= macp_pkg::ST_LINE;
            end
          end
        end
        macp_pkg::ST_SKIP: begin
          if (take && (ch == macp_pkg::CH_CR || ch == macp_pkg::CH_ESC ||
                       ch == macp_pkg::CH_RESET)) begin
            state_q <= macp_pkg::ST_IDLE;
          end
        end
        macp_pkg::ST_ECHO: begin
          // Whole line, then CR LF, sent only after the terminator.
          if (send_ok) begin
            if (echo_q < len_q) begin
              echo_q <= echo_q + 6'h01;
            end else if (!echo_tail_q) begin
              echo_tail_q <= 1'b1;
            end else begin
              state_q <= macp_pkg::ST_IDLE;
              len_q <= 6'h00;
            end
          end
        end
        macp_pkg::ST_LNUM: begin
          if (send_ok) begin
            if (lnum_q == 2'h0) begin
              state_q <= macp_pkg::ST_IDLE;
            end else begin
              lnum_q <= lnum_q - 2'h1;
            end
          end
        end
        macp_pkg::ST_NAME_CHAR: begin
          if (take) begin
            state_q <= is_letter ? macp_pkg::ST_NAME_OK : macp_pkg::ST_IDLE;
          end
        end
        macp_pkg::ST_NAME_OK: begin
          if (take) begin
            state_q <= macp_pkg::ST_IDLE;
          end
        end
        default: state_q <= macp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (take && (state_q == macp_pkg::ST_IDLE || state_q == macp_pkg::ST_LINE) &&
        is_legal && len_q < 6'(LINE_DEPTH) &&
        !(multi_axis_o && state_q == macp_pkg::ST_IDLE)) begin
      line_q[len_q[4:0]] <= ch;
    end
  end

  // ==========================================================
  // Axis name and mode
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      name_cand_q <= 8'h00;
      axis_name_o <= 8'h41;
    end else if (take && state_q == macp_pkg::ST_NAME_CHAR) begin
      name_cand_q <= ch;
    end else if (take && state_q == macp_pkg::ST_NAME_OK && ch == macp_pkg::CH_CONFIRM) begin
      axis_name_o <= name_cand_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      multi_axis_o <= 1'b0;
    end else if (take && ch == macp_pkg::CH_MULTI) begin
      multi_axis_o <= 1'b1;
    end else if (take && ch == macp_pkg::CH_RESET) begin
      multi_axis_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      reset_cmd_o <= 1'b0;
      escape_cmd_o <= 1'b0;
    end else begin
      reset_cmd_o <= take && ch == macp_pkg::CH_RESET;
      escape_cmd_o <= take && ch == macp_pkg::CH_ESC;
    end
  end

  // ==========================================================
  // Transmit and hand-over
  always_comb begin
    tx_valid_o = 1'b0;
    tx_data_o = 8'h00;
    if (state_q == macp_pkg::ST_ECHO) begin
      tx_valid_o = 1'b1;
      if (echo_q < len_q) begin
        tx_data_o = line_q[echo_q[4:0]];
      end else begin
        tx_data_o = echo_tail_q ? macp_pkg::CH_LF : macp_pkg::CH_CR;
      end
    end else if (state_q == macp_pkg::ST_LNUM) begin
      tx_valid_o = 1'b1;
      tx_data_o = lnum_char;
    end
  end

  logic [7:0] first_ch;
  logic [7:0] arg_ch;
  logic is_motion;
  assign first_ch = line_q[0];
  // The value may touch the command letter or follow a single space.
  assign arg_ch = (line_q[1] == macp_pkg::CH_SPACE) ? line_q[2] : line_q[1];
  assign is_motion = first_ch == 8'h2B || first_ch == 8'h2D || first_ch == 8'h52 ||
                     first_ch == 8'h4D;
  assign line_char_o = line_q[line_idx_i];
  assign line_len_o = len_q;

  logic [2:0] size_now;
  logic [10:0] last_loc;
  logic vector_ok;
  assign size_now = is_motion ? macp_pkg::MOTION_SIZE : macp_pkg::OTHER_SIZE;
  assign last_loc = {1'b0, prog_line_i} + 11'(size_now) - 11'h001;
  // Location 192 may hold only the branch vector, and it must end below the parameters.
  assign vector_ok = prog_line_i == macp_pkg::AUTO_START && first_ch == 8'h47 &&
                     last_loc < 11'(macp_pkg::PARAM_FIRST);

  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      line_done_o <= 1'b0;
      store_program_nonvolatile_o <= 1'b0;
      cmd_size_o <= 3'h0;
      addr_fault_o <= 1'b0;
    end else begin
      line_done_o <= take && ch == macp_pkg::CH_CR &&
                     (state_q == macp_pkg::ST_LINE ||
                      (state_q == macp_pkg::ST_IDLE && !multi_axis_o));
      store_program_nonvolatile_o <= take && ch == macp_pkg::CH_CR &&
                                     state_q == macp_pkg::ST_LINE && first_ch == 8'h53 &&
                                     arg_ch == 8'h31 && len_q <= 6'h03;
      if (take && ch == macp_pkg::CH_CR && prog_entry_i) begin
        cmd_size_o <= size_now;
        // Code may not leave the first page, use 192 to 255 except for the vector at 192, or pass the last location.
        addr_fault_o <= (prog_line_i <= macp_pkg::PROG_PAGE0_LAST &&
                         last_loc > 11'(macp_pkg::PROG_PAGE0_LAST)) ||
                        (prog_line_i >= macp_pkg::AUTO_START &&
                         prog_line_i <= macp_pkg::PARAM_LAST && !vector_ok) ||
                        last_loc > 11'(macp_pkg::PROG_LAST);
      end
    end
  end

  // ==========================================================
  // Checks
  escape_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    take && ch == macp_pkg::CH_ESC |=> state_q == macp_pkg::ST_IDLE && len_q == 6'h00)
    else $error("escape did not clear the line");
  multi_enter_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    take && ch == macp_pkg::CH_MULTI |=> multi_axis_o && !tx_valid_o)
    else $error("multi-axis entry failed");
  no_early_echo_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    state_q == macp_pkg::ST_LINE |-> !tx_valid_o)
    else $error("echo before terminator");
  cr_echo_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    take && ch == macp_pkg::CH_CR && state_q == macp_pkg::ST_LINE |=>
    state_q == macp_pkg::ST_ECHO && line_done_o)
    else $error("terminator did not start interpretation");
  foreign_skip_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    state_q == macp_pkg::ST_SKIP |-> !tx_valid_o && !line_done_o)
    else $error("foreign line acted on");
  name_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    multi_axis_o |-> $stable(axis_name_o))
    else $error("name changed in multi-axis mode");
  bs_lnum_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    take && prog_entry_i && ch == macp_pkg::CH_BS && state_q == macp_pkg::ST_LINE |=>
    state_q == macp_pkg::ST_LNUM && len_q == 6'h00)
    else $error("backspace did not reset line");
  bcast_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_q)
    take && ch == macp_pkg::CH_RESET |=> reset_cmd_o)
    else $error("reset broadcast missed");
endmodule

// ==== macp_pkg.sv ====
// Constants shared by the command-line parser and its receive queue.
// Assumes a byte-wide receive stream from a UART already framed on core_clk_i.
package macp_pkg;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_RESET = 8'h03;
  localparam logic [7:0] CH_NAME = 8'h0E;
  localparam logic [7:0] CH_MULTI = 8'h10;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_CONFIRM = 8'h79;
  localparam logic [7:0] CH_PROMPT = 8'h3F;
  localparam logic [9:0] PROG_PAGE0_LAST = 10'h0BF;
  localparam logic [9:0] AUTO_START = 10'h0C0;
  localparam logic [9:0] PARAM_FIRST = 10'h0C8;
  localparam logic [9:0] PARAM_LAST = 10'h0FF;
  localparam logic [9:0] PROG_LAST = 10'h3FF;
  localparam logic [2:0] MOTION_SIZE = 3'h5;
  localparam logic [2:0] OTHER_SIZE = 3'h3;
  localparam int LINE_DEPTH = 32;
  localparam int QUEUE_DEPTH = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LINE = 3'b001,
    ST_ECHO = 3'b011,
    ST_SKIP = 3'b010,
    ST_NAME_CHAR = 3'b110,
    ST_NAME_OK = 3'b111,
    ST_LNUM = 3'b101
  } macp_state_t;
endpackage

// ==== macp_rx_queue.sv ====
// Receive queue between the UART and the parser.
// Assumes the reader stalls it while motion stepping has priority.
`timescale 1ns/1ps
module macp_rx_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ==== macp_host_model.sv ====
// Host terminal model on the far side of the parser's byte streams.
// Assumes the parser's valid/ready handshakes, all on core_clk_i.
`timescale 1ns/1ps
module macp_host_model (
  input wire logic core_clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] echo_q[$];
  int seed = 26375;
  bit slow = 1'b0;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end

  // ==========================================================================
  // Echo collection
  // Sampling at the falling edge sees settled values for the next rising edge.
  always @(negedge core_clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      echo_q.push_back(tx_data_i);
    end
  end

  // A slow host stalls the echo at random so the held byte is exercised.
  always @(posedge core_clk_i) begin
    #1 tx_ready_o <= slow ? 1'($random(seed)) : 1'b1;
  end

  // ==========================================================================
  // Byte sender
  // The caller ends lines with 0Dh, or with ESC or BS to drop them, and waits for any echo first.
  task automatic put_byte(input logic [7:0] b);
    @(posedge core_clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o = b;
    forever begin
      @(negedge core_clk_i);
      if (rx_ready_i === 1'b1) break;
    end
    @(posedge core_clk_i);
    #1;
    rx_valid_o = 1'b0;
    // A released line must not look like a repeat of the last byte.
    rx_data_o = ~b;
  endtask
endmodule

// ==== tb_multi_axis_command_line_parser.sv ====
// Self-checking bench for the command-line parser.
// Assumes the host model file is compiled first; runs at 250 MHz.
`timescale 1ns/1ps
module tb_multi_axis_command_line_parser;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic stepping_busy_i = 1'b0;
  logic prog_entry_i = 1'b0;
  logic program_mode_i = 1'b0;
  logic [9:0] prog_line_i = 10'h000;
  logic [4:0] line_idx_i = 5'h00;
  logic rx_valid, rx_ready, tx_valid, tx_ready, line_done_o, multi_axis_o;
  logic reset_cmd_o, escape_cmd_o, store_program_nonvolatile_o, addr_fault_o;
  logic [7:0] rx_data, tx_data, line_char_o, axis_name_o;
  logic [5:0] line_len_o, last_len;
  logic [2:0] cmd_size_o;
  int failures = 0, compares = 0, cycles = 0, seed = 26375;
  int n_done = 0, n_rst = 0, n_esc = 0, n_store = 0;

  always #2 core_clk_i = ~core_clk_i;

  macp_parser macp_parser_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready), .stepping_busy_i(stepping_busy_i),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
    .prog_entry_i(prog_entry_i), .program_mode_i(program_mode_i), .prog_line_i(prog_line_i),
    .line_done_o(line_done_o), .line_len_o(line_len_o), .line_idx_i(line_idx_i),
    .line_char_o(line_char_o), .multi_axis_o(multi_axis_o), .axis_name_o(axis_name_o),
    .reset_cmd_o(reset_cmd_o), .escape_cmd_o(escape_cmd_o),
    .store_program_nonvolatile_o(store_program_nonvolatile_o), .cmd_size_o(cmd_size_o),
    .addr_fault_o(addr_fault_o));

  macp_host_model macp_host_model_i (.core_clk_i(core_clk_i), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready));

  // ==========================================================================
  // Pulse counters and timeout
  always @(posedge core_clk_i) begin
    cycles++;
    if (line_done_o === 1'b1) begin
      n_done++;
      last_len = line_len_o;
    end
    if (reset_cmd_o === 1'b1) n_rst++;
    if (escape_cmd_o === 1'b1) n_esc++;
    if (store_program_nonvolatile_o === 1'b1) n_store++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic put_str(input string s);
    for (int i = 0; i < s.len(); i++) macp_host_model_i.put_byte(s[i]);
  endtask

  task automatic send(input string s);
    put_str(s);
    macp_host_model_i.put_byte(macp_pkg::CH_CR);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // The echo is the stored line, then CR and LF.
  function automatic string echo_of(input string body);
    return {body, "\r\n"};
  endfunction

  task automatic expect_echo(input string s);
    string e;
    int k;
    e = echo_of(s);
    k = 0;
    while (macp_host_model_i.echo_q.size() < e.len() && k < 400) begin
      @(posedge core_clk_i);
      k++;
    end
    idle(4);
    check(macp_host_model_i.echo_q.size(), e.len(), "echo length");
    for (int i = 0; i < e.len() && macp_host_model_i.echo_q.size() > 0; i++)
      check(macp_host_model_i.echo_q.pop_front(), e[i], "echo byte");
    macp_host_model_i.echo_q = {};
  endtask

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    string s;
    int d;
    repeat (6) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    idle(3);
    check(axis_name_o, 8'h41, "name at reset");
    check(multi_axis_o, 1'b0, "mode at reset");
    put_str("V1");
    idle(12);
    check(macp_host_model_i.echo_q.size(), 0, "early echo");
    check(n_done, 0, "early line");
    macp_host_model_i.put_byte(macp_pkg::CH_CR);
    expect_echo("V1");
    check({last_len, line_char_o}, {6'h02, 8'h56}, "line store");
    line_idx_i = 5'h01;
    #1 check(line_char_o, 8'h31, "line index");
    for (int n = 0; n < 24; n++) begin
      macp_host_model_i.slow = n[0];
      d = n_done;
      s = "";
      s = {s, string'(8'h41 + 8'(($random(seed) & 32'h7FFFFFFF) % 18))};
      for (int j = $random(seed) & 7; j > 0; j--) s = {s, string'(8'h30 + 8'(j % 10)), " "};
      send(s);
      expect_echo(s);
      check(n_done - d, 1, "random line count");
      check(last_len, 6'(s.len()), "random line length");
    end
    macp_host_model_i.slow = 1'b0;
    stepping_busy_i = 1'b1;
    d = n_done;
    send("V7");
    idle(20);
    check(n_done, d, "busy stall");
    stepping_busy_i = 1'b0;
    expect_echo("V7");
    d = n_done;
    put_str("M5");
    macp_host_model_i.put_byte(macp_pkg::CH_ESC);
    idle(10);
    check(n_done - d, 0, "escape drop");
    check(n_esc, 1, "escape pulse");
    check(macp_host_model_i.echo_q.size(), 0, "escape echo");
    send("V3");
    expect_echo("V3");
    send("S1");
    expect_echo("S1");
    send("S 1");
    expect_echo("S 1");
    check(n_store, 2, "store pulses");
    prog_entry_i = 1'b1;
    prog_line_i = 10'h02A;
    send("+100");
    expect_echo("+100");
    check(cmd_size_o, macp_pkg::MOTION_SIZE, "motion size");
    check(addr_fault_o, 1'b0, "motion in page");
    prog_line_i = 10'h0C8;
    send("V1");
    expect_echo("V1");
    check(cmd_size_o, macp_pkg::OTHER_SIZE, "other size");
    check(addr_fault_o, 1'b1, "parameter area");
    prog_line_i = 10'h0BE;
    send("+100");
    expect_echo("+100");
    check(addr_fault_o, 1'b1, "page spill");
    prog_line_i = 10'h0C0;
    send("G5");
    expect_echo("G5");
    check(addr_fault_o, 1'b0, "vector at 192");
    prog_line_i = 10'h02A;
    put_str("V");
    macp_host_model_i.put_byte(macp_pkg::CH_BS);
    idle(40);
    check(macp_host_model_i.echo_q.size() >= 3, 1, "number echo");
    check({macp_host_model_i.echo_q[0], macp_host_model_i.echo_q[1],
      macp_host_model_i.echo_q[2]}, {"042"}, "line number");
    macp_host_model_i.echo_q = {};
    send("W0");
    expect_echo("W0");
    prog_entry_i = 1'b0;
    put_str(string'({macp_pkg::CH_NAME, "by"}));
    idle(20);
    check(axis_name_o, 8'h62, "name set");
    put_str(string'({macp_pkg::CH_NAME, "5y"}));
    idle(20);
    check(axis_name_o, 8'h62, "name not letter");
    macp_host_model_i.put_byte(macp_pkg::CH_CR);
    expect_echo("y");
    program_mode_i = 1'b1;
    put_str(string'({macp_pkg::CH_NAME, "cy"}));
    idle(20);
    check(axis_name_o, 8'h62, "name in program mode");
    macp_host_model_i.put_byte(macp_pkg::CH_CR);
    expect_echo("cy");
    program_mode_i = 1'b0;
    macp_host_model_i.echo_q = {};
    macp_host_model_i.put_byte(macp_pkg::CH_MULTI);
    idle(20);
    check({multi_axis_o, 31'(macp_host_model_i.echo_q.size())}, {1'b1, 31'h0}, "multi");
    send("bV2");
    expect_echo("V2");
    check(last_len, 6'h02, "prefix length");
    d = n_done;
    send("cV2");
    idle(60);
    check(n_done - d, 0, "other axis line");
    check(macp_host_model_i.echo_q.size(), 0, "other axis echo");
    macp_host_model_i.put_byte(macp_pkg::CH_ESC);
    macp_host_model_i.put_byte(macp_pkg::CH_RESET);
    idle(10);
    check(n_esc, 2, "broadcast escape");
    check(n_rst, 1, "broadcast reset");
    check(multi_axis_o, 1'b0, "reset leaves multi");
    stop_test();
  end
endmodule
